//--- src/tpo_timer.sv
// triggered pwm and one-shot pulse timer core with compare buffers
// assumes sys_clk is the count clock and ext_trig comes from a pin
//
// Rules for this block and for the software that drives it
// RULE_01 - software writes width compare last
// RULE_02 - change both: cycle first, then width
// RULE_03 - cycle only: rewrite width unchanged
// RULE_04 - width write arms buffer load at clear
// RULE_05 - no rewrite before period match irq
// RULE_06 - width zero gives 0% output
// RULE_07 - width cycle plus one gives 100%
// RULE_08 - trigger after width match restarts active
// RULE_09 - trigger before width match suppresses irq
// RULE_10 - trigger after period match clears counter
// RULE_11 - trigger before period match suppresses irq
// RULE_12 - pwm width irq fires on match
// RULE_13 - mode 011 selects one-shot mode
// RULE_14 - aux out active while one-shot counts; the code drives it active only when a software trigger starts the count
// RULE_15 - one-shot trigger takes ffff to 0000
// RULE_16 - after pulse, counter ffff and halted
// RULE_17 - one-shot ignores triggers during pulse
// RULE_18 - one-shot delay and width from compares
// RULE_19 - one-shot irq timing from buffers
// RULE_20 - trigger from pin edge or software
// RULE_21 - mode 010 selects retriggered pwm
// RULE_22 - pwm width and cycle from compares
`timescale 1ns/1ps
module tpo_timer
	import tpo_pkg::*;
(
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic count_enable_bit,
	input wire logic [2:0] mode_select_field,
	input wire logic soft_trigger_bit,
	input wire logic ext_trig,
	input wire logic ext_rise_en,
	input wire logic ext_fall_en,
	input wire tpo_wr_t wr,
	output logic [15:0] cycle_compare_reg,
	output logic [15:0] width_compare_reg,
	output logic [15:0] count_value,
	output tpo_out_t outs
);
	logic [SYNC_STAGES-1:0] sync_q;
	logic [15:0] cnt_q, cnt_d;
	logic [15:0] cyc_q, wid_q, cyc_buf_q, wid_buf_q;
	logic arm_q, pulse_q, pulse_d, aux_q, aux_d, pirq_q, pirq_d;
	logic lvl_q;
	tpo_state_t st_q, st_d;

	// pin synchroniser, change counted when stages two and three agree
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			sync_q <= '0;
			lvl_q <= 1'b0;
		end else begin
			sync_q <= {sync_q[SYNC_STAGES-2:0], ext_trig};
			// level only follows once stages two and three agree
			lvl_q <= sync_agree ? sync_q[2] : lvl_q;
		end
	end

	// decode of mode and trigger sources
	wire mode_pwm = (mode_select_field == MODE_TRIG_PWM); // [RULE_21]
	wire mode_os = (mode_select_field == MODE_ONE_SHOT); // [RULE_13]
	wire mode_ok = mode_pwm | mode_os;
	wire sync_agree = (sync_q[1] == sync_q[2]);
	wire ext_rise = sync_agree & sync_q[2] & ~lvl_q;
	wire ext_fall = sync_agree & ~sync_q[2] & lvl_q;
	wire ext_edge = (ext_rise & ext_rise_en) | (ext_fall & ext_fall_en);
	wire trig = ext_edge | soft_trigger_bit; // [RULE_20]
	wire running = (st_q == ST_RUN);
	wire waiting = (st_q == ST_WAIT);
	wire [15:0] cnt_inc = cnt_q + 16'h0001;
	wire at_period = running & (cnt_q == cyc_buf_q);
	// output changes on the count that reaches the width value
	wire width_next = running & (cnt_inc == wid_buf_q);
	// in one-shot a trigger during the pulse run is dropped
	wire os_trig_ok = mode_os & trig & waiting; // [RULE_17]
	wire pwm_trig = mode_pwm & trig & (waiting | running);
	wire start = os_trig_ok | pwm_trig;
	// counter clear at period end, buffers load then
	wire period_clear = at_period & ~pwm_trig;
	wire load_bufs = arm_q & (period_clear | start); // [RULE_04]
	// a copy in this cycle already decides the output level
	wire [15:0] wid_eff = load_bufs ? wid_q : wid_buf_q;
	// width irq as the counter lands on the width; dropped on coincident pwm retrigger
	wire wirq_hit = running & (cnt_d == wid_buf_q) & ~pwm_trig;
	wire wirq_pwm = mode_pwm & wirq_hit; // [RULE_12] [RULE_09]
	wire wirq_os = mode_os & wirq_hit; // [RULE_19]

	// compare registers written by software; width write arms the copy
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cyc_q <= CMP_RESET;
			wid_q <= CMP_RESET;
			arm_q <= 1'b0;
		end else begin
			if (wr.cycle_we) begin
				cyc_q <= wr.wdata; // [RULE_02] [RULE_03]
			end
			if (wr.width_we) begin
				wid_q <= wr.wdata; // [RULE_01]
			end
			// a fresh width write wins over the clear at load time
			if (wr.width_we) begin
				arm_q <= 1'b1; // [RULE_04] [RULE_05]
			end else if (load_bufs) begin
				arm_q <= 1'b0;
			end
		end
	end

	// buffers used for comparison
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cyc_buf_q <= CMP_RESET;
			wid_buf_q <= CMP_RESET;
		end else if (load_bufs) begin
			cyc_buf_q <= cyc_q; // [RULE_04]
			wid_buf_q <= wid_q;
		end
	end

	// state, counter and pin next values
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		pulse_d = pulse_q;
		aux_d = aux_q;
		pirq_d = 1'b0;
		case (st_q)
			ST_IDLE: begin
				cnt_d = CNT_FULL;
				pulse_d = 1'b0;
				aux_d = 1'b0;
				if (count_enable_bit && mode_ok) begin
					st_d = ST_WAIT;
				end
			end
			ST_WAIT: begin
				cnt_d = CNT_FULL;
				pulse_d = 1'b0;
				aux_d = 1'b0; // [RULE_14]
				if (start) begin
					st_d = ST_RUN;
					cnt_d = CNT_ZERO; // [RULE_15]
					// pwm output asserts from count zero unless width zero
					// one-shot with width zero starts its pulse at once
					pulse_d = mode_pwm ? (wid_eff != CNT_ZERO) : (wid_eff == CNT_ZERO);
					aux_d = mode_os ? soft_trigger_bit : ~aux_q;
				end
			end
			ST_RUN: begin
				cnt_d = cnt_inc;
				if (mode_pwm) begin
					if (pwm_trig) begin
						// retrigger clears and keeps counting; output active unless width zero
						cnt_d = CNT_ZERO; // [RULE_08] [RULE_10] [RULE_11]
						pulse_d = (wid_eff != CNT_ZERO);
					end else if (at_period) begin
						cnt_d = CNT_ZERO; // [RULE_22]
						pirq_d = 1'b1;
						pulse_d = (wid_eff != CNT_ZERO); // [RULE_06] [RULE_07]
						aux_d = ~aux_q;
					end else if (width_next) begin
						pulse_d = 1'b0; // [RULE_22]
					end
				end else begin
					if (at_period) begin
						// pulse complete: park at full scale
						st_d = ST_WAIT; // [RULE_16]
						cnt_d = CNT_FULL;
						pirq_d = 1'b1; // [RULE_19]
						pulse_d = 1'b0;
						aux_d = 1'b0;
					end else if (width_next) begin
						pulse_d = 1'b1; // [RULE_18]
					end
				end
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
		if (!count_enable_bit || !mode_ok) begin
			st_d = ST_IDLE;
			cnt_d = CNT_FULL;
			pulse_d = 1'b0;
			aux_d = 1'b0;
		end
	end

	// period irq one count after match; pulse and aux registered
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_q <= ST_IDLE;
			cnt_q <= CNT_FULL;
			pulse_q <= 1'b0;
			aux_q <= 1'b0;
			pirq_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			pulse_q <= pulse_d;
			aux_q <= aux_d;
			pirq_q <= pirq_d;
		end
	end

	// width irq registered from the next count value, so it shows while the counter holds the width
	logic wirq_q;
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			wirq_q <= 1'b0;
		end else begin
			wirq_q <= wirq_pwm | wirq_os;
		end
	end

	assign cycle_compare_reg = cyc_q;
	assign width_compare_reg = wid_q;
	assign count_value = cnt_q;
	assign outs.period_match_irq = pirq_q;
	assign outs.width_match_irq = wirq_q;
	assign outs.pulse_out = pulse_q;
	assign outs.aux_out = aux_q;

	// one-shot halts at full scale after period end
	a_os_park: assert property (@(posedge sys_clk) disable iff (srst)
		mode_os && count_enable_bit && at_period |=> cnt_q == CNT_FULL && waiting) // [RULE_16]
		else $error("one-shot did not park");
	// one-shot start from full scale to zero
	a_os_start: assert property (@(posedge sys_clk) disable iff (srst)
		mode_os && count_enable_bit && waiting && trig |=> running && cnt_q == CNT_ZERO) // [RULE_15]
		else $error("one-shot start wrong");
	// one-shot ignores triggers while running
	a_os_ignore: assert property (@(posedge sys_clk) disable iff (srst)
		mode_os && count_enable_bit && running && !at_period && trig |=> cnt_q == $past(cnt_q) + 16'h0001) // [RULE_17]
		else $error("one-shot retriggered");
	// pwm retrigger clears counter
	a_pwm_retrig: assert property (@(posedge sys_clk) disable iff (srst)
		mode_pwm && count_enable_bit && running && trig |=> cnt_q == CNT_ZERO) // [RULE_21]
		else $error("pwm retrigger missed");
	// pwm width irq suppressed on coincident trigger
	a_pwm_wsupp: assert property (@(posedge sys_clk) disable iff (srst)
		mode_pwm && count_enable_bit && width_next && trig |=> !outs.width_match_irq) // [RULE_09]
		else $error("width irq not suppressed");
	// pwm period irq suppressed on coincident trigger
	a_pwm_psupp: assert property (@(posedge sys_clk) disable iff (srst)
		mode_pwm && count_enable_bit && at_period && trig |=> !outs.period_match_irq) // [RULE_11]
		else $error("period irq not suppressed");
	// width irq flags alongside the output drop in pwm
	a_pwm_wtime: assert property (@(posedge sys_clk) disable iff (srst)
		mode_pwm && count_enable_bit && width_next && !at_period && !trig |=> outs.width_match_irq && !outs.pulse_out) // [RULE_12]
		else $error("width irq timing wrong");
	// buffers take compare values at a clear after a width write
	a_buf_load: assert property (@(posedge sys_clk) disable iff (srst)
		arm_q && !wr.width_we && !wr.cycle_we && load_bufs |=> cyc_buf_q == cyc_q && wid_buf_q == wid_q && !arm_q) // [RULE_04]
		else $error("buffer load wrong");
	// aux low while waiting in one-shot
	a_os_aux: assert property (@(posedge sys_clk) disable iff (srst)
		mode_os && waiting |-> !outs.aux_out) // [RULE_14]
		else $error("aux active while waiting");
	// one-shot pulse rises at width match
	a_os_rise: assert property (@(posedge sys_clk) disable iff (srst)
		mode_os && count_enable_bit && width_next && !at_period |=> outs.pulse_out) // [RULE_18]
		else $error("one-shot pulse late");
	// one-shot pulse ends with the period match
	a_os_fall: assert property (@(posedge sys_clk) disable iff (srst) // [RULE_18]
		mode_os && count_enable_bit && at_period |=> !outs.pulse_out)
		else $error("one-shot pulse did not end");
	// one-shot width irq as the counter lands on the width
	a_os_wirq: assert property (@(posedge sys_clk) disable iff (srst) // [RULE_19]
		mode_os && count_enable_bit && width_next && !at_period |=> outs.width_match_irq)
		else $error("one-shot width irq missing");
	// pwm period end clears counter and flags the irq
	a_pwm_period: assert property (@(posedge sys_clk) disable iff (srst) // [RULE_22]
		mode_pwm && count_enable_bit && at_period && !trig |=> cnt_q == CNT_ZERO && outs.period_match_irq)
		else $error("pwm period end wrong");
	// pwm retrigger asserts the output at once
	a_pwm_restart: assert property (@(posedge sys_clk) disable iff (srst) // [RULE_08]
		mode_pwm && count_enable_bit && running && trig && wid_eff != CNT_ZERO |=> outs.pulse_out && cnt_q == CNT_ZERO)
		else $error("pwm retrigger output low");
	// width one past the cycle keeps the output high
	a_pwm_full: assert property (@(posedge sys_clk) disable iff (srst) // [RULE_07]
		mode_pwm && count_enable_bit && running && !trig && !load_bufs && wid_buf_q == cyc_buf_q + 16'h0001
		|=> outs.pulse_out)
		else $error("full duty output dropped");
	// width zero keeps a low output low
	a_pwm_zero: assert property (@(posedge sys_clk) disable iff (srst) // [RULE_06]
		mode_pwm && count_enable_bit && !load_bufs && wid_buf_q == CNT_ZERO && !outs.pulse_out |=> !outs.pulse_out)
		else $error("zero duty output rose");
	// software trigger starts a waiting timer
	a_trig_soft: assert property (@(posedge sys_clk) disable iff (srst) // [RULE_20]
		count_enable_bit && mode_ok && waiting && soft_trigger_bit |=> running)
		else $error("software trigger not taken");
	// software started one-shot drives aux active
	a_os_aux_soft: assert property (@(posedge sys_clk) disable iff (srst) // [RULE_14]
		mode_os && count_enable_bit && waiting && soft_trigger_bit |=> outs.aux_out)
		else $error("aux not active while counting");
	// width write arms the buffer copy
	a_buf_arm: assert property (@(posedge sys_clk) disable iff (srst) // [RULE_04]
		wr.width_we |=> arm_q)
		else $error("width write did not arm");
endmodule

//--- src/tpo_pkg.sv
// constants and carrier types for the triggered pwm / one-shot timer
// assumes one clock domain; the count clock is the block clock
package tpo_pkg;
	localparam logic [2:0] MODE_TRIG_PWM = 3'b010;
	localparam logic [2:0] MODE_ONE_SHOT = 3'b011;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [15:0] CNT_FULL = 16'hffff;
	localparam logic [15:0] CMP_RESET = 16'h0000;
	localparam int SYNC_STAGES = 3;

	// software write strobes with data
	typedef struct packed {
		logic cycle_we;
		logic width_we;
		logic [15:0] wdata;
	} tpo_wr_t;

	// interrupt and pin outputs
	typedef struct packed {
		logic period_match_irq;
		logic width_match_irq;
		logic pulse_out;
		logic aux_out;
	} tpo_out_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_RUN = 2'b10
	} tpo_state_t;
endpackage

//--- bench/tpo_tb.sv
// self-checking bench for the triggered pwm / one-shot timer
// assumes tpo_pkg is compiled first; drives every port directly
`timescale 1ns/1ps
module testbench;
	import tpo_pkg::*;
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	logic count_enable_bit = 1'b0;
	logic [2:0] mode_select_field = 3'h0;
	logic soft_trigger_bit = 1'b0;
	logic ext_trig = 1'b0;
	logic ext_rise_en = 1'b0;
	logic ext_fall_en = 1'b0;
	tpo_wr_t wr = '0;
	logic [15:0] cycle_compare_reg;
	logic [15:0] width_compare_reg;
	logic [15:0] count_value;
	tpo_out_t outs;
	int fail_count = 0;
	int n_tests = 0;
	int cycles = 0;
	int i;

	tpo_timer DUT (.sys_clk(sys_clk), .srst(srst), .count_enable_bit(count_enable_bit),
		.mode_select_field(mode_select_field), .soft_trigger_bit(soft_trigger_bit), .ext_trig(ext_trig),
		.ext_rise_en(ext_rise_en), .ext_fall_en(ext_fall_en), .wr(wr), .cycle_compare_reg(cycle_compare_reg),
		.width_compare_reg(width_compare_reg), .count_value(count_value), .outs(outs));

	// 50 mhz count clock
	always #10 sys_clk = ~sys_clk;

	// one compare, counted, mismatch printed at once
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish;
		if (fail_count == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// advance one clock, sample settled outputs
	task automatic tick;
		@(posedge sys_clk);
		#1;
	endtask

	// counter, pulse, width irq, period irq together
	task automatic want(input logic [15:0] c, input logic p, input logic w, input logic pi);
		check({12'h000, count_value, outs.pulse_out, outs.width_match_irq, outs.period_match_irq, 1'b0},
			{12'h000, c, p, w, pi, 1'b0});
	endtask

	// cycle first, width last so the pair is armed
	task automatic write_cmp(input logic [15:0] cyc, input logic [15:0] wid);
		@(posedge sys_clk) wr <= '{cycle_we: 1'b1, width_we: 1'b0, wdata: cyc};
		@(posedge sys_clk) wr <= '{cycle_we: 1'b0, width_we: 1'b1, wdata: wid};
		@(posedge sys_clk) wr <= '0;
		#1;
	endtask

	// software trigger, sampled on the second edge
	task automatic trig;
		@(posedge sys_clk) soft_trigger_bit <= 1'b1;
		@(posedge sys_clk) soft_trigger_bit <= 1'b0;
		#1;
	endtask

	task automatic start(input logic [2:0] m);
		@(posedge sys_clk) count_enable_bit <= 1'b0;
		mode_select_field <= m;
		@(posedge sys_clk) count_enable_bit <= 1'b1;
		tick;
		tick;
	endtask

	// hang guard
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			tally_and_finish();
		end
	end

	initial begin
		repeat (10) @(posedge sys_clk);
		srst <= 1'b0;
		#1;
		want(16'hffff, 1'b0, 1'b0, 1'b0);
		check({cycle_compare_reg, width_compare_reg}, 32'h0);
		// triggered pwm, cycle 3 width 2
		start(MODE_TRIG_PWM);
		write_cmp(16'h0003, 16'h0002);
		check({cycle_compare_reg, width_compare_reg}, 32'h00030002);
		trig;
		want(16'h0000, 1'b1, 1'b0, 1'b0);
		tick;
		want(16'h0001, 1'b1, 1'b0, 1'b0);
		tick;
		want(16'h0002, 1'b0, 1'b1, 1'b0);
		tick;
		want(16'h0003, 1'b0, 1'b0, 1'b0);
		tick;
		want(16'h0000, 1'b1, 1'b0, 1'b1);
		// retrigger mid period restarts the count
		trig;
		want(16'h0000, 1'b1, 1'b0, 1'b0);
		tick;
		want(16'h0001, 1'b1, 1'b0, 1'b0);
		// full duty: width one past the cycle never matches
		start(MODE_TRIG_PWM);
		write_cmp(16'h0003, 16'h0004);
		trig;
		want(16'h0000, 1'b1, 1'b0, 1'b0);
		tick;
		want(16'h0001, 1'b1, 1'b0, 1'b0);
		tick;
		want(16'h0002, 1'b1, 1'b0, 1'b0);
		tick;
		want(16'h0003, 1'b1, 1'b0, 1'b0);
		tick;
		want(16'h0000, 1'b1, 1'b0, 1'b1);
		// cycle only, width rewritten unchanged after the period irq
		write_cmp(16'h0002, 16'h0004);
		tick;
		want(16'h0000, 1'b1, 1'b0, 1'b1);
		tick;
		want(16'h0001, 1'b1, 1'b0, 1'b0);
		tick;
		want(16'h0002, 1'b1, 1'b0, 1'b0);
		tick;
		want(16'h0000, 1'b1, 1'b0, 1'b1);
		// zero duty: output stays low, width irq each period
		start(MODE_TRIG_PWM);
		write_cmp(16'h0003, 16'h0000);
		trig;
		want(16'h0000, 1'b0, 1'b0, 1'b0);
		tick;
		want(16'h0001, 1'b0, 1'b0, 1'b0);
		tick;
		want(16'h0002, 1'b0, 1'b0, 1'b0);
		tick;
		want(16'h0003, 1'b0, 1'b0, 1'b0);
		tick;
		want(16'h0000, 1'b0, 1'b1, 1'b1);
		// one-shot, cycle 3 width 1
		start(MODE_ONE_SHOT);
		want(16'hffff, 1'b0, 1'b0, 1'b0);
		check({31'h0, outs.aux_out}, 32'h0);
		write_cmp(16'h0003, 16'h0001);
		trig;
		want(16'h0000, 1'b0, 1'b0, 1'b0);
		check({31'h0, outs.aux_out}, 32'h1);
		trig;
		want(16'h0002, 1'b1, 1'b0, 1'b0);
		tick;
		want(16'h0003, 1'b1, 1'b0, 1'b0);
		tick;
		want(16'hffff, 1'b0, 1'b0, 1'b1);
		tick;
		want(16'hffff, 1'b0, 1'b0, 1'b0);
		check({31'h0, outs.aux_out}, 32'h0);
		// external rising edge starts the one-shot
		@(posedge sys_clk) ext_rise_en <= 1'b1;
		ext_trig <= 1'b1;
		for (i = 0; i < 10 && count_value !== 16'h0000; i++)
			tick;
		want(16'h0000, 1'b0, 1'b0, 1'b0);
		tally_and_finish();
	end
endmodule
